// file: inc/ppm_map.svh
// constants for the parallel pin mux and strap block
// What this block does
// R1 - printer mode: upper data pins bidirectional bus
// R2 - single extension: bit3 is drive B read data
// R3 - dual extension: bit3 pulled-up shared read data
// R4 - extension modes: bit4 pulled-up disk change input
// R5 - extension modes: bit5 tri-stated
// R6 - single extension: bits 6 and 7 tri-stated
// R7 - dual extension: bit6 open-drain motor-on A
// R8 - dual extension: bit7 open-drain drive-select A
// R9 - send-request A strap gives port select bit
// R10 - terminal-ready A strap clears default enables
// R11 - serial B output strap gives reg24 bit1
// R12 - send-request, terminal-ready driven low when ready
// R13 - modem drives carrier, ring inputs low
// R14 - serial ports transmit and receive on pins
// R15 - straps captured at reset release
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH
`define PPM_CONFIG_REG_26_PORT_SEL_BIT 6
`define PPM_CONFIG_REG_24_DEF_CLR_BIT  0
`define PPM_CONFIG_REG_24_SERB_BIT     1
`define PPM_DATA_LSB          3
`define PPM_DATA_W            5
`endif

// file: inc/ppm_pkg.sv
// types for the parallel pin mux and strap block
package ppm_pkg;
	typedef enum logic [2:0] {
		PPM_PRINTER = 3'h1,
		PPM_EXT_ONE = 3'h2,
		PPM_EXT_TWO = 3'h4
	} ppm_mode_e;
	typedef struct packed {
		logic cfg_port_select_strap;
		logic default_enable_clear_strap;
		logic serial_b_strap;
		logic in_reset;
	} ppm_state_s;
endpackage

// file: design/ppm_strap.sv
// strap capture for the serial-port output pins
`timescale 1ns/100ps
module ppm_strap
	import ppm_pkg::*;
(
	// clock and reset
	input  wire logic MCLK,
	input  wire logic RST,
	// strap pin levels
	input  wire logic rts_a_in,
	input  wire logic dtr_a_in,
	input  wire logic sout_b_in,
	// captured values
	output logic      cfg_port_select_strap,
	output logic      default_enable_clear_strap,
	output logic      serial_b_strap,
	output logic      strap_phase
);
	import ppm_pkg::*;
	ppm_state_s st;
	ppm_state_s next_st;

	always_comb begin
		next_st = st;
		next_st.in_reset = RST;
		// sample continuously while reset holds; last sample at release stands [R15]
		if (RST) begin
			next_st.cfg_port_select_strap      = rts_a_in;  // [R9]
			next_st.default_enable_clear_strap = dtr_a_in;  // [R10]
			next_st.serial_b_strap             = sout_b_in; // [R11]
		end
	end

	// reset gives no constant here: the pins themselves are the reset value
	always_ff @(posedge MCLK) begin
		st <= next_st;
	end

	assign cfg_port_select_strap      = st.cfg_port_select_strap;
	assign default_enable_clear_strap = st.default_enable_clear_strap;
	assign serial_b_strap             = st.serial_b_strap;
	assign strap_phase                = RST;
endmodule

// file: design/ppm_top.sv
// pin mux for upper parallel data bits and serial strap pins
`timescale 1ns/100ps
`include "ppm_map.svh"
module ppm_top
	import ppm_pkg::*;
(
	// clock and reset
	input  wire logic                    MCLK,
	input  wire logic                    RST,
	// mode
	input  wire ppm_pkg::ppm_mode_e      MODE,
	// printer data path, bits 3..7
	input  wire logic [4:0]              PRN_DATA_OUT,
	input  wire logic                    PRN_DATA_DRIVE,
	output logic      [4:0]              PRN_DATA_IN,
	// parallel data pins 3..7
	input  wire logic [4:0]              PAR_DATA_I,
	output logic      [4:0]              PAR_DATA_O,
	output logic      [4:0]              PAR_DATA_OE_N,
	output logic      [4:0]              PAR_DATA_PULLUP,
	// floppy controller side
	input  wire logic                    EXT_MOTOR_ON_A_N,
	input  wire logic                    EXT_DRIVE_SELECT_A_N,
	output logic                         EXT_READ_DATA_N,
	output logic                         EXT_DISK_CHANGE_N,
	// serial cores
	input  wire logic                    UA_RTS_N,
	input  wire logic                    UA_DTR_N,
	input  wire logic                    UA_SOUT,
	input  wire logic                    UB_RTS_N,
	input  wire logic                    UB_DTR_N,
	input  wire logic                    UB_SOUT,
	output logic                         UA_SIN,
	output logic                         UA_DCD_N,
	output logic                         UA_RI_N,
	output logic                         UB_SIN,
	output logic                         UB_DCD_N,
	output logic                         UB_RI_N,
	// serial pins
	input  wire logic                    RTS_A_I,
	input  wire logic                    DTR_A_I,
	input  wire logic                    SOUT_B_I,
	input  wire logic                    SIN_A_PIN,
	input  wire logic                    SIN_B_PIN,
	input  wire logic                    DCD_A_PIN_N,
	input  wire logic                    RI_A_PIN_N,
	input  wire logic                    DCD_B_PIN_N,
	input  wire logic                    RI_B_PIN_N,
	output logic                         RTS_A_PIN_N,
	output logic                         DTR_A_PIN_N,
	output logic                         SOUT_A_PIN,
	output logic                         RTS_B_PIN_N,
	output logic                         DTR_B_PIN_N,
	output logic                         SOUT_B_PIN,
	output logic                         STRAP_PULLDOWN,
	// captured configuration bits
	output logic                         CONFIG_REG_26_BIT6,
	output logic                         CONFIG_REG_24_BIT0,
	output logic                         CONFIG_REG_24_BIT1
);
	import ppm_pkg::*;
	logic strap_phase;
	logic ext_mode;

	ppm_strap u_strap (
		.MCLK                      (MCLK),
		.RST                       (RST),
		.rts_a_in                  (RTS_A_I),
		.dtr_a_in                  (DTR_A_I),
		.sout_b_in                 (SOUT_B_I),
		.cfg_port_select_strap     (CONFIG_REG_26_BIT6),
		.default_enable_clear_strap(CONFIG_REG_24_BIT0),
		.serial_b_strap            (CONFIG_REG_24_BIT1),
		.strap_phase               (strap_phase)
	);

	assign ext_mode = (MODE == PPM_EXT_ONE) || (MODE == PPM_EXT_TWO);

	always_comb begin
		PAR_DATA_O      = PRN_DATA_OUT;
		PAR_DATA_OE_N   = 5'h1f;
		PAR_DATA_PULLUP = 5'h00;
		PRN_DATA_IN     = PAR_DATA_I;
		case (MODE)
			PPM_PRINTER: begin
				PAR_DATA_OE_N = {5{~PRN_DATA_DRIVE}}; // [R1]
			end
			PPM_EXT_ONE: begin
				// bits 5..7 stay off the wire [R5] [R6]
				PAR_DATA_PULLUP = 5'h03; // [R2] [R4]
				PRN_DATA_IN     = 5'h00;
			end
			PPM_EXT_TWO: begin
				PAR_DATA_PULLUP = 5'h03; // [R3] [R4]
				PRN_DATA_IN     = 5'h00;
				// open drain: only ever pull low [R7] [R8]
				PAR_DATA_O       = 5'h00;
				PAR_DATA_OE_N[3] = EXT_MOTOR_ON_A_N;     // [R7]
				PAR_DATA_OE_N[4] = EXT_DRIVE_SELECT_A_N; // [R8]
			end
			default: begin
				PRN_DATA_IN = 5'h00;
			end
		endcase
	end

	// undriven inputs read high in extension modes; idle high otherwise
	assign EXT_READ_DATA_N   = ext_mode ? PAR_DATA_I[0] : 1'b1; // [R2] [R3]
	assign EXT_DISK_CHANGE_N = ext_mode ? PAR_DATA_I[1] : 1'b1; // [R4]

	// weak pull-down on strap pins enabled while reset holds; RTS_A_PIN_N, DTR_A_PIN_N, SOUT_B_PIN still follow the serial cores [R9] [R10] [R11]
	assign STRAP_PULLDOWN = strap_phase;
	assign RTS_A_PIN_N = UA_RTS_N; // [R12]
	assign DTR_A_PIN_N = UA_DTR_N; // [R12]
	assign RTS_B_PIN_N = UB_RTS_N; // [R12]
	assign DTR_B_PIN_N = UB_DTR_N; // [R12]
	assign SOUT_A_PIN  = UA_SOUT;  // [R14]
	assign SOUT_B_PIN  = UB_SOUT;  // [R14]
	assign UA_SIN      = SIN_A_PIN; // [R14]
	assign UB_SIN      = SIN_B_PIN; // [R14]
	// modem signals are active low as delivered [R13]
	assign UA_DCD_N    = DCD_A_PIN_N;
	assign UA_RI_N     = RI_A_PIN_N;
	assign UB_DCD_N    = DCD_B_PIN_N;
	assign UB_RI_N     = RI_B_PIN_N;
endmodule

// file: test/ppm_top_props.sv
// checker for the parallel pin mux and strap block
`timescale 1ns/100ps
module ppm_top_chk
	import ppm_pkg::*;
(
	input wire logic MCLK, RST, PRN_DATA_DRIVE, EXT_MOTOR_ON_A_N, EXT_DRIVE_SELECT_A_N, EXT_READ_DATA_N,
	input wire logic EXT_DISK_CHANGE_N, RTS_A_I, DTR_A_I, SOUT_B_I,
	input wire logic CONFIG_REG_26_BIT6, CONFIG_REG_24_BIT0, CONFIG_REG_24_BIT1,
	input wire ppm_pkg::ppm_mode_e MODE,
	input wire logic [4:0] PRN_DATA_OUT, PRN_DATA_IN, PAR_DATA_I, PAR_DATA_O, PAR_DATA_OE_N
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	wire ext = MODE == PPM_EXT_ONE || MODE == PPM_EXT_TWO;
	a_port_strap: assert property ($fell(RST) |-> CONFIG_REG_26_BIT6 == $past(RTS_A_I)) else $error("port");
	a_clear_strap: assert property ($fell(RST) |-> CONFIG_REG_24_BIT0 == $past(DTR_A_I)) else $error("clr");
	a_serb_strap: assert property ($fell(RST) |-> CONFIG_REG_24_BIT1 == $past(SOUT_B_I)) else $error("serb");
	a_strap_hold: assert property (!$past(RST) |->
		$stable({CONFIG_REG_26_BIT6, CONFIG_REG_24_BIT0, CONFIG_REG_24_BIT1})) else $error("hold");
	a_single_off: assert property (MODE == PPM_EXT_ONE |-> PAR_DATA_OE_N[4:2] == 3'h7) else $error("one");
	a_dual_drive: assert property (MODE == PPM_EXT_TWO |-> PAR_DATA_O[4:3] == 2'h0 &&
		PAR_DATA_OE_N[4:2] == {EXT_DRIVE_SELECT_A_N, EXT_MOTOR_ON_A_N, 1'b1}) else $error("two");
	a_ext_inputs: assert property (ext |-> {EXT_READ_DATA_N, EXT_DISK_CHANGE_N} == {PAR_DATA_I[0], PAR_DATA_I[1]}
		&& PAR_DATA_OE_N[1:0] == 2'h3) else $error("ext");
	a_printer_bus: assert property (MODE == PPM_PRINTER |-> PRN_DATA_IN == PAR_DATA_I &&
		PAR_DATA_O == PRN_DATA_OUT && PAR_DATA_OE_N == {5{!PRN_DATA_DRIVE}}) else $error("prn");
	cover property (MODE == PPM_EXT_TWO && !EXT_MOTOR_ON_A_N);
	cover property (MODE == PPM_PRINTER && PRN_DATA_DRIVE);
	cover property ($fell(RST));
endmodule
bind ppm_top ppm_top_chk chk_i (.*);

// file: test/ppm_modem.sv
// modem model on the serial pins
`timescale 1ns/100ps
module ppm_modem (
	input  wire logic sout, carrier, ring,
	output logic      sin, dcd_n, ri_n
);
	assign sin = sout; // echo so both directions carry data
	assign dcd_n = !carrier;
	assign ri_n = !ring;
endmodule

// file: test/parallel_port_pin_mux_and_straps_tb_top.sv
// self-checking bench for the parallel pin mux and strap block
`timescale 1ns/100ps
module parallel_port_pin_mux_and_straps_tb_top;
	import ppm_pkg::*;
	logic MCLK=0, RST=1, PRN_DATA_DRIVE=0, EXT_MOTOR_ON_A_N=1, EXT_DRIVE_SELECT_A_N=1, EXT_READ_DATA_N;
	logic EXT_DISK_CHANGE_N, UA_RTS_N=1, UA_DTR_N=1, UA_SOUT=1, UB_RTS_N=1, UB_DTR_N=1, UB_SOUT=1;
	logic UA_SIN, UA_DCD_N, UA_RI_N, UB_SIN, UB_DCD_N, UB_RI_N, RTS_A_I=1, DTR_A_I=0, SOUT_B_I=1;
	logic SIN_A_PIN, SIN_B_PIN, DCD_A_PIN_N, RI_A_PIN_N, DCD_B_PIN_N, RI_B_PIN_N, RTS_A_PIN_N, DTR_A_PIN_N;
	logic SOUT_A_PIN, RTS_B_PIN_N, DTR_B_PIN_N, SOUT_B_PIN, STRAP_PULLDOWN, car=0, ring=0;
	logic CONFIG_REG_26_BIT6, CONFIG_REG_24_BIT0, CONFIG_REG_24_BIT1;
	logic [4:0] PRN_DATA_OUT=0, PRN_DATA_IN, PAR_DATA_I=0, PAR_DATA_O, PAR_DATA_OE_N, PAR_DATA_PULLUP;
	ppm_mode_e MODE = PPM_PRINTER;
	int n_fail=0, comparisons=0;
	ppm_top uut (.*);
	ppm_modem mdm_a (.sout(SOUT_A_PIN), .carrier(car), .ring(ring), .sin(SIN_A_PIN), .dcd_n(DCD_A_PIN_N), .ri_n(RI_A_PIN_N));
	ppm_modem mdm_b (.sout(SOUT_B_PIN), .carrier(car), .ring(ring), .sin(SIN_B_PIN), .dcd_n(DCD_B_PIN_N), .ri_n(RI_B_PIN_N));
	task chk(input logic [15:0] g, e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t: got %h want %h", $time, g, e);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial forever #20 MCLK = ~MCLK;
	// run takes about 28 cycles
	initial begin
		#12000 n_fail++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge MCLK);
		#1 chk(16'(STRAP_PULLDOWN), 16'h1);
		@(posedge MCLK) RST <= 0;
		// pins flipped after release must not reach the captured bits
		@(posedge MCLK) {SOUT_B_I, DTR_A_I, RTS_A_I} <= 3'h2;
		repeat (2) @(posedge MCLK);
		#1 chk({STRAP_PULLDOWN, CONFIG_REG_24_BIT1, CONFIG_REG_24_BIT0, CONFIG_REG_26_BIT6}, 16'h5);
		for (int m = 0; m < 3; m++) for (int k = 0; k < 4; k++) begin
			@(posedge MCLK);
			MODE <= ppm_mode_e'(3'h1 << m);
			PAR_DATA_I <= 5'(k * 11);
			PRN_DATA_OUT <= 5'(k * 13 + 5);
			{car, ring, PRN_DATA_DRIVE, EXT_MOTOR_ON_A_N, EXT_DRIVE_SELECT_A_N} <= 5'(k * 7 + m);
			{UB_RTS_N, UB_DTR_N, UB_SOUT, UA_RTS_N, UA_DTR_N, UA_SOUT} <= 6'(k * 21 + m);
			#1 chk(PAR_DATA_OE_N, m == 0 ? {5{!PRN_DATA_DRIVE}} :
				m == 1 ? 5'h1f : {EXT_DRIVE_SELECT_A_N, EXT_MOTOR_ON_A_N, 3'h7});
			if (m == 0) chk({PRN_DATA_IN, PAR_DATA_O}, {PAR_DATA_I, PRN_DATA_OUT});
			else chk({EXT_READ_DATA_N, EXT_DISK_CHANGE_N, PAR_DATA_PULLUP[1:0]}, {PAR_DATA_I[0], PAR_DATA_I[1], 2'h3});
			if (m == 2) chk(16'(PAR_DATA_O[4:3]), 16'h0);
			if (m == 0) chk({EXT_READ_DATA_N, EXT_DISK_CHANGE_N, PAR_DATA_PULLUP}, {2'h3, 5'h00});
			else chk(16'(PRN_DATA_IN), 16'h0);
			chk({RTS_B_PIN_N, DTR_B_PIN_N, SOUT_B_PIN, RTS_A_PIN_N, DTR_A_PIN_N, SOUT_A_PIN, UA_SIN, UA_DCD_N,
				UA_RI_N, UB_SIN, UB_DCD_N, UB_RI_N}, {UB_RTS_N, UB_DTR_N, UB_SOUT, UA_RTS_N, UA_DTR_N, UA_SOUT,
				UA_SOUT, !car, !ring, UB_SOUT, !car, !ring});
		end
		// second reset in mid-run with new strap levels and an undefined mode code
		@(posedge MCLK) begin
			RST <= 1;
			{SOUT_B_I, DTR_A_I, RTS_A_I} <= 3'h6;
			MODE <= ppm_mode_e'(3'h0);
		end
		repeat (2) @(posedge MCLK);
		#1 chk({PAR_DATA_OE_N, EXT_READ_DATA_N, EXT_DISK_CHANGE_N}, {5'h1f, 2'h3});
		chk({PAR_DATA_PULLUP, PRN_DATA_IN}, 10'h000);
		chk({STRAP_PULLDOWN, CONFIG_REG_24_BIT1, CONFIG_REG_24_BIT0, CONFIG_REG_26_BIT6}, 16'he);
		@(posedge MCLK) RST <= 0;
		@(posedge MCLK) {SOUT_B_I, DTR_A_I, RTS_A_I} <= 3'h1;
		repeat (2) @(posedge MCLK);
		#1 chk({STRAP_PULLDOWN, CONFIG_REG_24_BIT1, CONFIG_REG_24_BIT0, CONFIG_REG_26_BIT6}, 16'h6);
		tally_and_finish;
	end
endmodule
